//--- daqs_consts.svh
`ifndef DAQS_CONSTS_SVH
`define DAQS_CONSTS_SVH
// Clock and aggregate sample rate limits, in their own units
`define DAQS_CLK_HZ 25000000
`define DAQS_CONT_MAX_SPS 1200
`define DAQS_BURST1_MAX_SPS 8000
`define DAQS_BURST2_MAX_SPS 4000
`define DAQS_BURST4_MAX_SPS 2000
// LED blink half periods in milliseconds
`define DAQS_FAST_HALF_MS 100
`define DAQS_SLOW_HALF_MS 500
// Sample buffer geometry
`define DAQS_FIFO_DEPTH 4096
`define DAQS_FIFO_AW 12
`define DAQS_BLOCK_WORDS 13'h0040
// Range code for the only single-ended range (+/-10 V)
`define DAQS_RANGE_10V 3'h1
// Number of flashes when the link first comes up
`define DAQS_FLASH_COUNT 3'h3
// Differential pairs: negative input is positive input plus this offset
`define DAQS_PAIR_OFFSET 3'h4
`endif

//--- daqs_pkg.sv
package daqs_pkg;
  typedef enum logic [1:0] {
    DAQS_MODE_SW,
    DAQS_MODE_CONT,
    DAQS_MODE_BURST
  } daqs_mode_t;

  typedef struct packed {
    daqs_mode_t mode;
    logic trigExt;       // Start on external trigger instead of command
    logic diffCfg;       // Differential input configuration
    logic [2:0] rangeSel;
    logic [2:0] firstChan;
    logic [3:0] chanCount;
    logic [15:0] paceDiv; // Requested cycles between conversions
  } daqs_cfg_t;

  typedef struct packed {
    logic [2:0] posSel;
    logic [2:0] negSel;
    logic diff;
    logic [2:0] gainSel;
  } daqs_mux_t;
endpackage

//--- daqs_acq_sequencer.sv
`timescale 1ns/100ps
`include "daqs_consts.svh"
// Behaviour
// - Software mode: one conversion per command
// - Continuous scan fills FIFO until stopped
// - Continuous aggregate rate limited to 1.2 kS/s
// - Scan starts on command or external trigger
// - Burst: one sequence, 1/2/4 channels
// - Burst stops at FIFO depth, then drained
// - Burst aggregate rate limit per channel count
// - LED steady while attached, nothing else
// - LED blinks fast during data transfer
// - LED flashes three times at link up
// - LED blinks slow while armed for trigger
// - LED always driven, never disabled
// - Differential 12-bit, single-ended 11-bit results
// - Single-ended: eight channels, only 10 V range
// - Differential: four channels, eight gain ranges
// - Differential result is positive minus negative input
// - LED off after link loss until reattached
module daqs_acq_sequencer #(
  parameter logic [15:0] CONT_MIN_CYC = 16'((`DAQS_CLK_HZ + `DAQS_CONT_MAX_SPS - 1) / `DAQS_CONT_MAX_SPS),
  parameter logic [15:0] BURST1_MIN_CYC = 16'((`DAQS_CLK_HZ + `DAQS_BURST1_MAX_SPS - 1) / `DAQS_BURST1_MAX_SPS),
  parameter logic [15:0] BURST2_MIN_CYC = 16'((`DAQS_CLK_HZ + `DAQS_BURST2_MAX_SPS - 1) / `DAQS_BURST2_MAX_SPS),
  parameter logic [15:0] BURST4_MIN_CYC = 16'((`DAQS_CLK_HZ + `DAQS_BURST4_MAX_SPS - 1) / `DAQS_BURST4_MAX_SPS),
  parameter logic [23:0] FAST_HALF_CYC = 24'(`DAQS_CLK_HZ / 1000 * `DAQS_FAST_HALF_MS),
  parameter logic [23:0] SLOW_HALF_CYC = 24'(`DAQS_CLK_HZ / 1000 * `DAQS_SLOW_HALF_MS)
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input daqs_pkg::daqs_cfg_t cfg,
  input wire logic cmdStart,
  input wire logic cmdStop,
  input wire logic overrunClear,
  input wire logic external_trigger_input,
  input wire logic linkAttached,
  input wire logic linkEstablished,
  output logic adcStart,
  output daqs_pkg::daqs_mux_t muxSel,
  input wire logic adcDone,
  input wire logic [11:0] adcData,
  output logic [11:0] singleData,
  output logic singleValid,
  input wire logic hostRead,
  output logic [11:0] hostData,
  output logic hostValid,
  output logic fifoEmpty,
  output logic blockReady,
  output logic overrun,
  output logic rangeUnsupported,
  output logic scanBusy,
  output logic statusLed
);
  typedef enum logic [2:0] {
    DAQS_IDLE,
    DAQS_ARMED,
    DAQS_RUN,
    DAQS_SINGLE,
    DAQS_DONE
  } daqs_state_t;

  typedef enum logic [2:0] {
    DAQS_LED_OFF,
    DAQS_LED_FLASH,
    DAQS_LED_ON,
    DAQS_LED_LOST
  } daqs_led_t;

  daqs_state_t state_ff;
  daqs_state_t nxt_state;
  daqs_pkg::daqs_cfg_t cfgLat_ff;
  logic [2:0] trigSync_ff;
  logic trigLvl_ff;
  logic trigEvent;
  logic [15:0] paceCnt_ff;
  logic [15:0] minCyc;
  logic [15:0] interval;
  logic adcBusy_ff;
  logic [3:0] chanIdx_ff;
  logic [3:0] chanTotal;
  logic [2:0] chanSum;
  logic [11:0] resData;
  logic [11:0] mem [`DAQS_FIFO_DEPTH];
  logic [`DAQS_FIFO_AW:0] wrPtr_ff;
  logic [`DAQS_FIFO_AW:0] rdPtr_ff;
  logic [`DAQS_FIFO_AW:0] fill;
  logic fifoFull;
  logic sampleIn;
  logic pushOk;
  logic popOk;
  logic dropSample;
  logic scanning;
  daqs_led_t ledState_ff;
  logic [23:0] blinkCnt_ff;
  logic blink_ff;
  logic [2:0] flashCnt_ff;
  logic linkEst_ff;
  logic [23:0] halfCyc;

  ////////////////////////////////////////////////////////////////////
  // Trigger pin: three stages, a level counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trigSync_ff <= 3'h0;
      trigLvl_ff <= 1'b0;
    end else begin
      trigSync_ff <= {trigSync_ff[1:0], external_trigger_input};
      if (trigSync_ff[1] == trigSync_ff[2]) begin
        trigLvl_ff <= trigSync_ff[2];
      end
    end
  end
  assign trigEvent = (trigSync_ff[1] == trigSync_ff[2]) && trigSync_ff[2] && !trigLvl_ff;

  ////////////////////////////////////////////////////////////////////
  // Pacing limits; a faster request from the host is stretched, never honoured
  always_comb begin
    chanTotal = (cfgLat_ff.chanCount == 4'h0) ? 4'h1 : cfgLat_ff.chanCount;
    if (cfgLat_ff.mode == daqs_pkg::DAQS_MODE_BURST) begin
      chanTotal = (cfgLat_ff.chanCount <= 4'h1) ? 4'h1 : (cfgLat_ff.chanCount == 4'h2) ? 4'h2 : 4'h4;
      minCyc = (chanTotal == 4'h1) ? BURST1_MIN_CYC : (chanTotal == 4'h2) ? BURST2_MIN_CYC : BURST4_MIN_CYC;
    end else begin
      minCyc = CONT_MIN_CYC;
    end
    if (!cfgLat_ff.diffCfg && chanTotal > 4'h8) begin
      chanTotal = 4'h8;
    end else if (cfgLat_ff.diffCfg && chanTotal > 4'h4) begin
      chanTotal = 4'h4;
    end
    interval = (cfgLat_ff.paceDiv < minCyc) ? minCyc : cfgLat_ff.paceDiv;
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      DAQS_IDLE: begin
        if (cmdStart && cfg.mode == daqs_pkg::DAQS_MODE_SW) begin
          nxt_state = DAQS_SINGLE;
        end else if (cmdStart) begin
          nxt_state = cfg.trigExt ? DAQS_ARMED : DAQS_RUN;
        end
      end
      DAQS_ARMED: begin
        if (cmdStop) begin
          nxt_state = DAQS_IDLE;
        end else if (trigEvent) begin
          nxt_state = DAQS_RUN;
        end
      end
      DAQS_RUN: begin
        if (cmdStop) begin
          nxt_state = DAQS_IDLE;
        end else if (cfgLat_ff.mode == daqs_pkg::DAQS_MODE_BURST && fifoFull) begin
          nxt_state = DAQS_DONE;
        end
      end
      DAQS_SINGLE: begin
        if (adcDone) begin
          nxt_state = DAQS_IDLE;
        end
      end
      DAQS_DONE: begin
        if (fifoEmpty || cmdStop) begin
          nxt_state = DAQS_IDLE;
        end
      end
      default: begin
        nxt_state = DAQS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= DAQS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Configuration is frozen at the start so a host write mid-scan cannot tear it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgLat_ff <= '0;
      rangeUnsupported <= 1'b0;
    end else if (state_ff == DAQS_IDLE && cmdStart) begin
      cfgLat_ff <= cfg;
      rangeUnsupported <= !cfg.diffCfg && cfg.rangeSel != `DAQS_RANGE_10V;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Conversion pacing and channel stepping
  assign scanning = (state_ff == DAQS_RUN);
  assign adcStart = (state_ff == DAQS_IDLE && nxt_state == DAQS_SINGLE) ||
                    (scanning && !cmdStop && paceCnt_ff == 16'h0 && !adcBusy_ff &&
                     !(cfgLat_ff.mode == daqs_pkg::DAQS_MODE_BURST && fifoFull));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      paceCnt_ff <= 16'h0;
    end else if (!scanning) begin
      paceCnt_ff <= 16'h0;
    end else if (adcStart) begin
      paceCnt_ff <= interval - 16'h1;
    end else if (paceCnt_ff != 16'h0) begin
      paceCnt_ff <= paceCnt_ff - 16'h1;
    end
  end

  // Continuous mode keeps pacing while full so an overrun is seen, not hidden
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      adcBusy_ff <= 1'b0;
    end else if (adcStart) begin
      adcBusy_ff <= 1'b1;
    end else if (adcDone) begin
      adcBusy_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chanIdx_ff <= 4'h0;
    end else if (state_ff == DAQS_IDLE) begin
      chanIdx_ff <= 4'h0;
    end else if (scanning && adcDone) begin
      chanIdx_ff <= (chanIdx_ff + 4'h1 >= chanTotal) ? 4'h0 : chanIdx_ff + 4'h1;
    end
  end

  // Mux selection: in differential mode the pair is wired low minus high
  assign chanSum = cfgLat_ff.firstChan + chanIdx_ff[2:0];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      muxSel <= '0;
    end else begin
      muxSel.diff <= cfgLat_ff.diffCfg;
      muxSel.posSel <= cfgLat_ff.diffCfg ? {1'b0, chanSum[1:0]} : chanSum;
      muxSel.negSel <= cfgLat_ff.diffCfg ? {1'b0, chanSum[1:0]} + `DAQS_PAIR_OFFSET : 3'h0;
      muxSel.gainSel <= cfgLat_ff.diffCfg ? cfgLat_ff.rangeSel : `DAQS_RANGE_10V;
    end
  end

  // Single-ended results lose the LSB; the converter only resolves 11 bits there
  assign resData = cfgLat_ff.diffCfg ? adcData : {adcData[11:1], 1'b0};

  ////////////////////////////////////////////////////////////////////
  // Single point result
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      singleData <= 12'h000;
      singleValid <= 1'b0;
    end else begin
      singleValid <= (state_ff == DAQS_SINGLE) && adcDone;
      if (state_ff == DAQS_SINGLE && adcDone) begin
        singleData <= resData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sample FIFO, drained by the host in blocks
  assign fill = wrPtr_ff - rdPtr_ff;
  assign fifoFull = (fill == 13'(`DAQS_FIFO_DEPTH));
  assign fifoEmpty = (fill == 13'h0000);
  assign sampleIn = scanning && adcDone;
  assign pushOk = sampleIn && !fifoFull;
  assign dropSample = sampleIn && fifoFull;
  assign popOk = hostRead && !fifoEmpty;
  assign blockReady = (fill >= `DAQS_BLOCK_WORDS) || (state_ff == DAQS_DONE && !fifoEmpty);
  assign scanBusy = (state_ff != DAQS_IDLE);

  always_ff @(posedge ref_clk) begin
    if (pushOk) begin
      mem[wrPtr_ff[`DAQS_FIFO_AW-1:0]] <= resData;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
    end else if (state_ff == DAQS_IDLE && cmdStart) begin
      wrPtr_ff <= '0; // Each new scan starts with an empty buffer
      rdPtr_ff <= '0;
    end else begin
      if (pushOk) begin
        wrPtr_ff <= wrPtr_ff + 13'h0001;
      end
      if (popOk) begin
        rdPtr_ff <= rdPtr_ff + 13'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hostData <= 12'h000;
      hostValid <= 1'b0;
    end else begin
      hostValid <= popOk;
      if (popOk) begin
        hostData <= mem[rdPtr_ff[`DAQS_FIFO_AW-1:0]];
      end
    end
  end

  // Sticky overrun; a drop in the clear cycle still sets it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun <= 1'b0;
    end else if (dropSample) begin
      overrun <= 1'b1;
    end else if (overrunClear) begin
      overrun <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Status LED: link state first, then trigger arm, then transfer activity
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      linkEst_ff <= 1'b0;
      ledState_ff <= DAQS_LED_OFF;
      flashCnt_ff <= 3'h0;
    end else begin
      linkEst_ff <= linkEstablished;
      case (ledState_ff)
        DAQS_LED_OFF: begin
          if (linkAttached && linkEstablished && !linkEst_ff) begin
            ledState_ff <= DAQS_LED_FLASH;
            flashCnt_ff <= 3'h0;
          end else if (linkAttached && linkEstablished) begin
            ledState_ff <= DAQS_LED_ON;
          end
        end
        DAQS_LED_FLASH: begin
          if (!linkAttached) begin
            ledState_ff <= DAQS_LED_OFF;
          end else if (blinkCnt_ff == 24'h0 && blink_ff) begin
            flashCnt_ff <= flashCnt_ff + 3'h1;
            if (flashCnt_ff + 3'h1 == `DAQS_FLASH_COUNT) begin
              ledState_ff <= DAQS_LED_ON;
            end
          end
        end
        DAQS_LED_ON: begin
          if (!linkAttached) begin
            ledState_ff <= DAQS_LED_OFF;
          end else if (!linkEstablished) begin
            ledState_ff <= DAQS_LED_LOST;
          end
        end
        DAQS_LED_LOST: begin
          if (!linkAttached) begin
            ledState_ff <= DAQS_LED_OFF;
          end
        end
        default: begin
          ledState_ff <= DAQS_LED_OFF;
        end
      endcase
    end
  end

  assign halfCyc = (state_ff == DAQS_ARMED) ? SLOW_HALF_CYC : FAST_HALF_CYC;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      blinkCnt_ff <= 24'h0;
      blink_ff <= 1'b0;
    end else if (blinkCnt_ff == 24'h0) begin
      blinkCnt_ff <= halfCyc - 24'h1;
      blink_ff <= !blink_ff;
    end else begin
      blinkCnt_ff <= blinkCnt_ff - 24'h1;
    end
  end

  // No enable input exists on purpose: the indicator cannot be switched off
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      statusLed <= 1'b0;
    end else begin
      case (ledState_ff)
        DAQS_LED_FLASH: statusLed <= blink_ff;
        DAQS_LED_ON: begin
          if (state_ff == DAQS_ARMED) begin
            statusLed <= blink_ff;
          end else if (scanning || !fifoEmpty) begin
            statusLed <= blink_ff;
          end else begin
            statusLed <= 1'b1;
          end
        end
        default: statusLed <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  single_one_conv_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_ff == DAQS_SINGLE) |-> !adcStart)
    else $error("extra conversion in single mode");
  single_result_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_ff == DAQS_SINGLE && adcDone) |=> singleValid && singleData == $past(resData))
    else $error("single result not returned");
  cont_pace_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (adcStart && scanning) |=> !adcStart [*7])
    else $error("conversions too close together");
  pace_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (adcStart && scanning && !cmdStop) |=> paceCnt_ff == $past(interval) - 16'h1 && paceCnt_ff >= $past(minCyc) - 16'h1)
    else $error("pacing interval below limit");
  trig_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_ff == DAQS_ARMED && trigEvent && !cmdStop) |=> state_ff == DAQS_RUN)
    else $error("trigger did not start scan");
  burst_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (scanning && cfgLat_ff.mode == daqs_pkg::DAQS_MODE_BURST && fifoFull && !cmdStop) |=> state_ff == DAQS_DONE)
    else $error("burst ran past buffer depth");
  overrun_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dropSample |=> overrun && $stable(wrPtr_ff))
    else $error("overrun lost or sample overwritten");
  se_resolution_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (singleValid && !cfgLat_ff.diffCfg) |-> singleData[0] == 1'b0)
    else $error("single-ended result has 12 bits");
  led_lost_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ledState_ff == DAQS_LED_LOST) |=> !statusLed)
    else $error("led lit after link loss");
  led_steady_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ledState_ff == DAQS_LED_ON && state_ff == DAQS_IDLE && fifoEmpty) |=> statusLed)
    else $error("led not steady while idle");
  cover_burst_c: cover property (@(posedge ref_clk) disable iff (!rst_n) state_ff == DAQS_DONE);
  cover_overrun_c: cover property (@(posedge ref_clk) disable iff (!rst_n) dropSample);
  cover_armed_c: cover property (@(posedge ref_clk) disable iff (!rst_n) state_ff == DAQS_ARMED ##1 state_ff == DAQS_RUN);
  cover_flash_c: cover property (@(posedge ref_clk) disable iff (!rst_n) ledState_ff == DAQS_LED_FLASH ##1 ledState_ff == DAQS_LED_ON);
endmodule

//--- daqs_adc_model.sv
`timescale 1ns/100ps
// Converter model: answers each start request after one or five cycles
module daqs_adc_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic adcStart,
  input daqs_pkg::daqs_mux_t muxSel,
  input wire logic slowMode,
  output logic adcDone,
  output logic [11:0] adcData
);
  logic [2:0] waitCnt;
  logic [11:0] resultFf;
  ////////////////////////////////////////////////////////////////////////
  // Result encodes the mux setting, sampled late so a registered mux has settled
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt <= 3'h0;
      adcDone <= 1'b0;
      resultFf <= 12'h000;
    end else begin
      adcDone <= 1'b0;
      if (adcStart) begin
        waitCnt <= slowMode ? 3'h5 : 3'h1;
      end else if (waitCnt != 3'h0) begin
        waitCnt <= waitCnt - 3'h1;
        adcDone <= (waitCnt == 3'h1);
        resultFf <= {muxSel, 2'h3};
      end
    end
  end
  // Outside the done pulse the bus shows the inverse, so a late capture is caught
  assign adcData = adcDone ? resultFf : ~resultFf;
endmodule

//--- daq_acquisition_sequencer_tb.sv
`timescale 1ns/100ps
`include "daqs_consts.svh"
module daq_acquisition_sequencer_tb;
  // Shortened pacing so a full buffer fits in the run
  localparam logic [15:0] CONT_CYC = 16'h0008;
  localparam logic [15:0] B1_CYC = 16'h0008;
  localparam logic [15:0] B2_CYC = 16'h000c;
  localparam logic [15:0] B4_CYC = 16'h0010;
  localparam int DEPTH = `DAQS_FIFO_DEPTH;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  daqs_pkg::daqs_cfg_t cfg = '0;
  logic cmdStart = 1'b0;
  logic cmdStop = 1'b0;
  logic overrunClear = 1'b0;
  logic trig = 1'b0;
  logic linkAttached = 1'b0;
  logic linkEstablished = 1'b0;
  logic hostRead = 1'b0;
  logic slowMode = 1'b0;
  logic adcStart, adcDone, singleValid, hostValid, fifoEmpty, blockReady;
  logic overrun, rangeUnsupported, scanBusy, statusLed;
  daqs_pkg::daqs_mux_t muxSel;
  logic [11:0] adcData, singleData, hostData, word;
  int n_fail = 0;
  int checks = 0;
  int nStarts, nValid, rises, falls, gapCnt, minGap, k, i, j, cc;
  logic prevLed = 1'b0;
  logic firstGap = 1'b1;

  always #20 ref_clk = ~ref_clk;

  daqs_acq_sequencer #(.CONT_MIN_CYC(CONT_CYC), .BURST1_MIN_CYC(B1_CYC), .BURST2_MIN_CYC(B2_CYC),
    .BURST4_MIN_CYC(B4_CYC), .FAST_HALF_CYC(24'h000004), .SLOW_HALF_CYC(24'h00000a)) i_daqs_acq_sequencer (
    .ref_clk(ref_clk), .rst_n(rst_n), .cfg(cfg), .cmdStart(cmdStart), .cmdStop(cmdStop),
    .overrunClear(overrunClear), .external_trigger_input(trig), .linkAttached(linkAttached),
    .linkEstablished(linkEstablished), .adcStart(adcStart), .muxSel(muxSel), .adcDone(adcDone),
    .adcData(adcData), .singleData(singleData), .singleValid(singleValid), .hostRead(hostRead),
    .hostData(hostData), .hostValid(hostValid), .fifoEmpty(fifoEmpty), .blockReady(blockReady),
    .overrun(overrun), .rangeUnsupported(rangeUnsupported), .scanBusy(scanBusy), .statusLed(statusLed));

  daqs_adc_model i_daqs_adc_model (.ref_clk(ref_clk), .rst_n(rst_n), .adcStart(adcStart), .muxSel(muxSel),
    .slowMode(slowMode), .adcDone(adcDone), .adcData(adcData));

  ////////////////////////////////////////////////////////////////////////
  // Monitor: start count and spacing, read answers, LED edges
  always @(posedge ref_clk) begin
    gapCnt++;
    if (adcStart === 1'b1) begin
      nStarts++;
      if (!firstGap && gapCnt < minGap) minGap = gapCnt;
      firstGap = 1'b0;
      gapCnt = 0;
    end
    if (hostValid === 1'b1) nValid++;
    if (statusLed === 1'b1 && prevLed === 1'b0) rises++;
    if (statusLed === 1'b0 && prevLed === 1'b1) falls++;
    prevLed = statusLed;
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare and drive helpers
  task chk1(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask
  task chk12(input string n, input logic [11:0] e, input logic [11:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task chkN(input string n, input int e, input int g);
    checks++;
    if (g != e) begin
      n_fail++;
      $display("MISMATCH %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task cycles(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Pulse lasts exactly one rising edge
  task automatic pulse(ref logic s);
    @(negedge ref_clk) s = 1'b1;
    @(negedge ref_clk) s = 1'b0;
  endtask
  task clearStats;
    nStarts = 0;
    nValid = 0;
    rises = 0;
    falls = 0;
    minGap = 65535;
    firstGap = 1'b1;
  endtask
  task setCfg(input daqs_pkg::daqs_mode_t m, input logic te, input logic d, input logic [2:0] rg,
              input logic [2:0] ch, input logic [3:0] n);
    cfg.mode = m;
    cfg.trigExt = te;
    cfg.diffCfg = d;
    cfg.rangeSel = rg;
    cfg.firstChan = ch;
    cfg.chanCount = n;
    cfg.paceDiv = 16'h0000;
  endtask
  task readWord(output logic [11:0] d);
    @(negedge ref_clk) hostRead = 1'b1;
    @(negedge ref_clk) hostRead = 1'b0;
    chk1("hostValid", 1'b1, hostValid);
    d = hostData;
  endtask
  // Single-ended results drop the lowest bit
  function logic [11:0] expData(input logic [2:0] p, input logic [2:0] n, input logic d, input logic [2:0] g);
    logic [11:0] v;
    v = {p, n, d, g, 2'h3};
    return d ? v : (v & 12'hffe);
  endfunction
  // A second command while busy must not start another conversion
  task swConv(input logic d, input logic [2:0] ch, input logic [2:0] rg, input logic [11:0] e);
    setCfg(daqs_pkg::DAQS_MODE_SW, 1'b0, d, rg, ch, 4'h1);
    clearStats;
    pulse(cmdStart);
    pulse(cmdStart);
    for (k = 0; k < 30 && singleValid !== 1'b1; k++) @(negedge ref_clk);
    chk1("singleValid", 1'b1, singleValid);
    chk12("singleData", e, singleData);
    chkN("startsPerCmd", 1, nStarts);
    cycles(2);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watchdog: full tests take about 71000 cycles
  initial begin
    repeat (95000) @(posedge ref_clk);
    n_fail++;
    $display("watchdog expired");
    test_done;
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk) rst_n = 1'b1;
    chk1("fifoEmpty", 1'b1, fifoEmpty);
    chk1("ledReset", 1'b0, statusLed);
    chk1("overrunReset", 1'b0, overrun);
    chk1("busyReset", 1'b0, scanBusy);
    clearStats;
    linkAttached = 1'b1;
    linkEstablished = 1'b1;
    cycles(40);
    chkN("ledFlashes", 1, int'(rises == 3 || rises == 4));
    clearStats;
    cycles(20);
    chkN("ledFalls", 0, falls);
    chk1("ledSteady", 1'b1, statusLed);
    $display("test link done");
    slowMode = 1'b1;
    for (i = 0; i < 8; i++) swConv(1'b0, 3'(i), 3'h1, expData(3'(i), 3'h0, 1'b0, 3'h1));
    chk1("rangeOk", 1'b0, rangeUnsupported);
    swConv(1'b0, 3'h3, 3'h3, expData(3'h3, 3'h0, 1'b0, 3'h1));
    chk1("rangeBad", 1'b1, rangeUnsupported);
    for (i = 0; i < 8; i++) swConv(1'b1, 3'(i % 4), 3'(i), expData(3'(i % 4), 3'(i % 4 + 4), 1'b1, 3'(i)));
    chk1("rangeDiff", 1'b0, rangeUnsupported);
    $display("test single done");
    slowMode = 1'b0;
    setCfg(daqs_pkg::DAQS_MODE_CONT, 1'b0, 1'b0, 3'h1, 3'h7, 4'h2);
    clearStats;
    pulse(cmdStart);
    for (k = 0; k < 2000 && blockReady !== 1'b1; k++) cycles(1);
    chk1("blockReady", 1'b1, blockReady);
    chkN("contGap", 1, int'(minGap >= CONT_CYC));
    chkN("ledBlink", 1, int'(rises >= 2));
    for (j = 0; j < 64; j++) begin
      readWord(word);
      chk12("contWord", expData((j % 2 == 0) ? 3'h7 : 3'h0, 3'h0, 1'b0, 3'h1), word);
    end
    for (k = 0; k < 40000 && overrun !== 1'b1; k++) cycles(1);
    chk1("overrun", 1'b1, overrun);
    readWord(word);
    chk12("noOverwrite", expData(3'h7, 3'h0, 1'b0, 3'h1), word);
    pulse(cmdStop);
    pulse(overrunClear);
    chk1("overrunClr", 1'b0, overrun);
    chk1("stopped", 1'b0, scanBusy);
    $display("test continuous done");
    setCfg(daqs_pkg::DAQS_MODE_BURST, 1'b1, 1'b0, 3'h1, 3'h5, 4'h1);
    clearStats;
    pulse(cmdStart);
    cycles(40);
    chkN("armedStarts", 0, nStarts);
    chkN("slowBlink", 1, int'(rises >= 1 && rises <= 3));
    chk1("armedBusy", 1'b1, scanBusy);
    trig = 1'b1;
    cycles(3);
    trig = 1'b0;
    for (k = 0; k < 40000 && nStarts < DEPTH; k++) cycles(1);
    cycles(50);
    chkN("burstLen", DEPTH, nStarts);
    chkN("burstGap", 1, int'(minGap >= B1_CYC));
    chk1("burstReady", 1'b1, blockReady);
    hostRead = 1'b1;
    for (k = 0; k < 5000 && fifoEmpty !== 1'b1; k++) cycles(1);
    hostRead = 1'b0;
    cycles(2);
    chkN("drained", DEPTH, nValid);
    chk12("burstWord", expData(3'h5, 3'h0, 1'b0, 3'h1), hostData);
    chk1("burstIdle", 1'b0, scanBusy);
    // Two and four pair bursts wrap modulo the four differential pairs
    for (i = 0; i < 2; i++) begin
      cc = (i == 0) ? 2 : 4;
      setCfg(daqs_pkg::DAQS_MODE_BURST, 1'b0, 1'b1, 3'h2, 3'h3, 4'(cc));
      clearStats;
      pulse(cmdStart);
      for (k = 0; k < 400 && nStarts < 5; k++) cycles(1);
      for (j = 0; j < 4; j++) begin
        readWord(word);
        chk12("burstPair", expData(3'((3 + j % cc) % 4), 3'((3 + j % cc) % 4 + 4), 1'b1, 3'h2), word);
      end
      pulse(cmdStop);
      chkN("pairGap", 1, int'(minGap >= ((cc == 2) ? B2_CYC : B4_CYC)));
      // Leftover words would keep the LED blinking through the link tests
      hostRead = 1'b1;
      for (k = 0; k < 100 && fifoEmpty !== 1'b1; k++) cycles(1);
      hostRead = 1'b0;
      chk1("pairDrained", 1'b1, fifoEmpty);
    end
    $display("test burst done");
    cycles(10);
    linkEstablished = 1'b0;
    cycles(5);
    chk1("ledLost", 1'b0, statusLed);
    clearStats;
    linkEstablished = 1'b1;
    cycles(30);
    chkN("ledStaysOff", 0, rises);
    linkAttached = 1'b0;
    cycles(2);
    linkAttached = 1'b1;
    cycles(40);
    chk1("ledBack", 1'b1, statusLed);
    $display("test loss done");
    test_done;
  end
endmodule
